// >>> src/wdt_gpio_regs.sv
// Runtime register block: supervision timer control and eight general-purpose pins
`timescale 1ns/1ps
`default_nettype none
module wdt_gpio_regs
    import wdt_gpio_pkg::*;
#(
    parameter int CYCLES_PER_SEC = CYCLES_PER_SECOND
) (
    input wire logic i_clock,                    // 40 MHz clock
    input wire logic i_reset,                    // Synchronous reset, active high
    input wire logic [15:0] i_io_addr,           // I/O port address
    input wire logic [7:0] i_io_wdata,           // I/O write data
    input wire logic i_io_write,                 // One-cycle I/O write strobe
    input wire logic i_io_read,                  // One-cycle I/O read strobe
    output logic [7:0] o_io_rdata,               // Read data, valid with o_io_rvalid
    output logic o_io_rvalid,                    // Read answer pulse
    output logic [PIN_COUNT-1:0] o_pin_level,    // Driven pin levels
    output logic [PIN_COUNT-1:0] o_pin_drive_en, // High while a pin is an output
    output logic o_wdt_reset                     // Timeout reset request, level
);
    supervision_timer_if wd ();

    logic [7:0] wdt_enable;
    logic unit_seconds;
    logic [7:0] timeout_value;
    logic timeout_status;
    logic [7:0] pin_output_level;
    logic [7:0] pin_direction [PIN_COUNT];
    logic in_window;
    logic [7:0] offset;
    logic wr;
    logic load_pending;
    logic [7:0] read_mux;

    // Decode only the 256-byte window above the base
    assign in_window = (i_io_addr[15:8] == IO_BASE[15:8]);
    assign offset = i_io_addr[7:0];
    assign wr = i_io_write && in_window;

    // Supervision timer control
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            wdt_enable <= RESET_ZERO;
            unit_seconds <= 1'b0;
            timeout_value <= RESET_ZERO;
        end else if (wr) begin
            if (offset == OFS_WDT_ENABLE) begin
                wdt_enable <= i_io_wdata;
            end
            if (offset == OFS_WDT_UNIT_CONFIG) begin
                unit_seconds <= i_io_wdata[UNIT_SELECT_BIT];
            end
            if (offset == OFS_WDT_TIMEOUT_VALUE) begin
                timeout_value <= i_io_wdata;
            end
        end
    end

    // Reload one cycle after the write so the timer sees the stored value
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            load_pending <= 1'b0;
        end else begin
            load_pending <= wr && (offset == OFS_WDT_TIMEOUT_VALUE
                || offset == OFS_WDT_ENABLE);
        end
    end

    assign wd.run = (wdt_enable == WDT_ENABLE_CODE) && (timeout_value != RESET_ZERO);
    assign wd.unit_seconds = unit_seconds;
    assign wd.load = load_pending;
    assign wd.load_value = timeout_value;

    supervision_timer #(
        .CYCLES_PER_SEC(CYCLES_PER_SEC)
    ) u_timer (
        .i_clock(i_clock),
        .i_reset(i_reset),
        .tmr(wd)
    );

    // Status: a timeout in the clearing cycle wins over the write of one
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            timeout_status <= 1'b0;
        end else if (wd.timeout) begin
            timeout_status <= 1'b1;
        end else if (wr && offset == OFS_WDT_UNIT_CONFIG && i_io_wdata[STATUS_BIT]) begin
            timeout_status <= 1'b0;
        end
    end

    // Reset request follows the status one cycle later
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_wdt_reset <= 1'b0;
        end else begin
            o_wdt_reset <= timeout_status;
        end
    end

    // Pin direction and output level registers
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            pin_output_level <= RESET_ZERO;
            for (int i = 0; i < PIN_COUNT; i++) begin
                pin_direction[i] <= RESET_DIRECTION;
            end
        end else if (wr) begin
            if (offset == OFS_PIN_OUTPUT_LEVEL) begin
                pin_output_level <= i_io_wdata;
            end
            for (int i = 0; i < PIN_COUNT; i++) begin
                if (offset == PIN_DIR_OFFSET[i]) begin
                    pin_direction[i] <= i_io_wdata;
                end
            end
        end
    end

    // Pin drivers; any direction value but 00h leaves the pin undriven
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_pin_level <= '0;
            o_pin_drive_en <= '0;
        end else begin
            for (int i = 0; i < PIN_COUNT; i++) begin
                o_pin_drive_en[i] <= (pin_direction[i] == DIR_PIN_OUTPUT_MODE);
                o_pin_level[i] <= pin_output_level[i];
            end
        end
    end

    // Read multiplexer; unmapped offsets in the window read as zero
    always_comb begin
        read_mux = RESET_ZERO;
        unique case (offset)
            OFS_WDT_ENABLE: read_mux = wdt_enable;
            OFS_WDT_UNIT_CONFIG: read_mux = {unit_seconds, 6'h00, timeout_status};
            OFS_WDT_TIMEOUT_VALUE: read_mux = timeout_value;
            OFS_PIN_OUTPUT_LEVEL: read_mux = pin_output_level;
            default: begin
                for (int i = 0; i < PIN_COUNT; i++) begin
                    if (offset == PIN_DIR_OFFSET[i]) begin
                        read_mux = pin_direction[i];
                    end
                end
            end
        endcase
    end

    // Read answer one cycle after the strobe
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_io_rdata <= RESET_ZERO;
            o_io_rvalid <= 1'b0;
        end else begin
            o_io_rvalid <= i_io_read && in_window;
            if (i_io_read && in_window) begin
                o_io_rdata <= read_mux;
            end
        end
    end

    sequence s_status_then_reset;
        timeout_status ##1 o_wdt_reset;
    endsequence

    property p_read_answer;
        @(posedge i_clock) disable iff (i_reset)
        i_io_read && i_io_addr[15:8] == IO_BASE[15:8] |=> o_io_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer) else $error("no read answer");

    property p_enable_code;
        @(posedge i_clock) disable iff (i_reset)
        wdt_enable != WDT_ENABLE_CODE |=> !wd.timeout;
    endproperty
    a_enable_code: assert property (p_enable_code) else $error("timeout without code");

    property p_zero_disables;
        @(posedge i_clock) disable iff (i_reset)
        timeout_value == RESET_ZERO && !wd.load |=> !wd.timeout;
    endproperty
    a_zero_disables: assert property (p_zero_disables) else $error("timeout at zero");

    property p_timeout_reset;
        @(posedge i_clock) disable iff (i_reset)
        wd.timeout |=> s_status_then_reset;
    endproperty
    a_timeout_reset: assert property (p_timeout_reset) else $error("timeout lost");

    property p_status_read;
        @(posedge i_clock) disable iff (i_reset)
        i_io_read && i_io_addr == (IO_BASE | 16'(OFS_WDT_UNIT_CONFIG))
        |=> o_io_rdata[STATUS_BIT] == $past(timeout_status);
    endproperty
    a_status_read: assert property (p_status_read) else $error("status misread");

    property p_pin7_input;
        @(posedge i_clock) disable iff (i_reset)
        i_io_write && i_io_addr == (IO_BASE | 16'(PIN_DIR_OFFSET[7]))
        && i_io_wdata == DIR_PIN_INPUT_MODE |=> ##1 !o_pin_drive_en[7];
    endproperty
    a_pin7_input: assert property (p_pin7_input) else $error("pin 7 still driven");

    property p_pin0_output;
        @(posedge i_clock) disable iff (i_reset)
        i_io_write && i_io_addr == (IO_BASE | 16'(PIN_DIR_OFFSET[0]))
        && i_io_wdata == DIR_PIN_OUTPUT_MODE |=> ##1 o_pin_drive_en[0];
    endproperty
    a_pin0_output: assert property (p_pin0_output) else $error("pin 0 not driven");

    property p_level_write;
        @(posedge i_clock) disable iff (i_reset)
        i_io_write && i_io_addr == (IO_BASE | 16'(OFS_PIN_OUTPUT_LEVEL))
        |=> ##1 o_pin_level == $past(i_io_wdata, 2);
    endproperty
    a_level_write: assert property (p_level_write) else $error("pin level wrong");
endmodule : wdt_gpio_regs
`default_nettype wire

// >>> common/wdt_gpio_pkg.sv
// Constants for the supervision timer and general-purpose pin register block
`default_nettype none
package wdt_gpio_pkg;
    // I/O window and register offsets
    localparam logic [15:0] IO_BASE = 16'h0a00;
    localparam logic [7:0] OFS_PIN_OUTPUT_LEVEL = 8'h4b;
    localparam logic [7:0] OFS_WDT_ENABLE = 8'h47;
    localparam logic [7:0] OFS_WDT_UNIT_CONFIG = 8'h65;
    localparam logic [7:0] OFS_WDT_TIMEOUT_VALUE = 8'h66;
    localparam int PIN_COUNT = 8;
    localparam logic [7:0] PIN_DIR_OFFSET [PIN_COUNT] = '{
        8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h29, 8'h2a, 8'h2b};
    // Field values and positions
    localparam logic [7:0] WDT_ENABLE_CODE = 8'h0c;
    localparam logic [7:0] DIR_PIN_OUTPUT_MODE = 8'h00;
    localparam logic [7:0] DIR_PIN_INPUT_MODE = 8'h01;
    localparam int UNIT_SELECT_BIT = 7;
    localparam int STATUS_BIT = 0;
    // Reset values
    localparam logic [7:0] RESET_ZERO = 8'h00;
    localparam logic [7:0] RESET_DIRECTION = DIR_PIN_INPUT_MODE;
    // Timing: one second expressed in clock cycles and one minute in seconds
    localparam longint CLOCK_PERIOD_PS = 25000;
    localparam longint SECOND_PS = 64'he8d4a51000; // Sized, the value does not fit 32 bits
    localparam int CYCLES_PER_SECOND = int'(SECOND_PS / CLOCK_PERIOD_PS);
    localparam int SECONDS_PER_MINUTE = 60;
endpackage : wdt_gpio_pkg
`default_nettype wire

// >>> common/supervision_timer_if.sv
// Control and event signals between the register block and the supervision timer
`timescale 1ns/1ps
`default_nettype none
interface supervision_timer_if;
    logic run;              // Enabled with a nonzero timeout value
    logic unit_seconds;     // 1 counts seconds, 0 counts minutes
    logic load;             // Restart the count from load_value
    logic [7:0] load_value; // Timeout value in units
    logic timeout;          // One-cycle pulse when the count reaches zero
    logic [7:0] remaining;  // Units left
    modport ctrl (output run, unit_seconds, load, load_value, input timeout, remaining);
    modport timer (input run, unit_seconds, load, load_value, output timeout, remaining);
endinterface : supervision_timer_if
`default_nettype wire

// >>> src/supervision_timer.sv
// Supervision timer: unit prescaler and timeout down-counter
`timescale 1ns/1ps
`default_nettype none
module supervision_timer
    import wdt_gpio_pkg::*;
#(
    parameter int CYCLES_PER_SEC = CYCLES_PER_SECOND
) (
    input wire logic i_clock,            // System clock
    input wire logic i_reset,            // Synchronous reset, active high
    supervision_timer_if.timer tmr       // Control from the register block
);
    logic [31:0] second_count;
    logic [5:0] minute_count;
    logic second_tick;
    logic minute_tick;
    logic unit_tick;

    // Tick decode; the minute tick falls on the last second of each minute
    assign second_tick = (second_count == 32'(CYCLES_PER_SEC - 1));
    assign minute_tick = second_tick && (minute_count == 6'(SECONDS_PER_MINUTE - 1));
    assign unit_tick = tmr.unit_seconds ? second_tick : minute_tick;

    // Prescaler restarts on every load so the first unit is always whole
    always_ff @(posedge i_clock) begin
        if (i_reset || !tmr.run || tmr.load) begin
            second_count <= '0;
            minute_count <= '0;
        end else if (second_tick) begin
            second_count <= '0;
            minute_count <= minute_tick ? 6'h00 : minute_count + 6'h01;
        end else begin
            second_count <= second_count + 32'h1;
        end
    end

    // Down-counter; it parks at zero until the next load
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            tmr.remaining <= RESET_ZERO;
        end else if (tmr.load) begin
            tmr.remaining <= tmr.load_value;
        end else if (tmr.run && unit_tick && tmr.remaining != RESET_ZERO) begin
            tmr.remaining <= tmr.remaining - 8'h01;
        end
    end

    // Timeout pulse on the step from one to zero
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            tmr.timeout <= 1'b0;
        end else begin
            tmr.timeout <= tmr.run && !tmr.load && unit_tick
                && tmr.remaining == 8'h01;
        end
    end

    property p_countdown;
        @(posedge i_clock) disable iff (i_reset)
        tmr.run && !tmr.load && unit_tick && tmr.remaining != 8'h00
        |=> tmr.remaining == $past(tmr.remaining) - 8'h01;
    endproperty
    a_countdown: assert property (p_countdown) else $error("count did not step down");

    property p_minute_unit;
        @(posedge i_clock) disable iff (i_reset)
        !tmr.unit_seconds && unit_tick
        |-> second_tick && minute_count == 6'(SECONDS_PER_MINUTE - 1);
    endproperty
    a_minute_unit: assert property (p_minute_unit) else $error("minute unit ticked early");

    property p_hold_between_ticks;
        @(posedge i_clock) disable iff (i_reset)
        !unit_tick && !tmr.load |=> $stable(tmr.remaining);
    endproperty
    a_hold_between_ticks: assert property (p_hold_between_ticks) else $error("count moved");
endmodule : supervision_timer
`default_nettype wire

// >>> verification/io_host_model.sv
// Host processor model issuing I/O port reads and writes
`timescale 1ns/1ps
`default_nettype none
module io_host_model (
    input wire logic i_clock,          // System clock
    input wire logic [7:0] i_io_rdata, // Read data from the block
    input wire logic i_io_rvalid,      // Read answer pulse
    output var logic [15:0] o_io_addr, // Port address
    output var logic [7:0] o_io_wdata, // Write data
    output var logic o_io_write,       // Write strobe
    output var logic o_io_read         // Read strobe
);
    // Idle bus at time zero, strobes low
    initial begin
        o_io_addr = 16'h0000;
        o_io_wdata = 8'h00;
        o_io_write = 1'b0;
        o_io_read = 1'b0;
    end

    // One write: strobe stands for one edge, then released lines carry junk, not old values
    task automatic io_write(input logic [15:0] addr, input logic [7:0] data);
        @(posedge i_clock);
        o_io_addr <= addr;
        o_io_wdata <= data;
        o_io_write <= 1'b1;
        @(posedge i_clock);
        o_io_write <= 1'b0;
        o_io_addr <= ~addr;
        o_io_wdata <= ~data;
    endtask : io_write

    // One read: answer sampled in the single cycle that it stands
    task automatic io_read(input logic [15:0] addr, output logic [7:0] data, output logic valid);
        @(posedge i_clock);
        o_io_addr <= addr;
        o_io_read <= 1'b1;
        @(posedge i_clock);
        o_io_read <= 1'b0;
        o_io_addr <= ~addr;
        #1;
        valid = i_io_rvalid;
        data = i_io_rdata;
    endtask : io_read
endmodule : io_host_model
`default_nettype wire

// >>> verification/test_watchdog_and_gpio_runtime_regs.sv
// Self-checking bench for the supervision timer and pin register block
`timescale 1ns/1ps
`default_nettype none
module test_watchdog_and_gpio_runtime_regs;
    import wdt_gpio_pkg::*;
    localparam int CPS = 4; // Short second keeps the minute run small
    logic i_clock = 1'b0;
    logic i_reset = 1'b1;
    logic [15:0] io_addr;
    logic [7:0] io_wdata, io_rdata, pin_level, pin_en, rd, exp_en;
    logic io_write, io_read, io_rvalid, wdt_reset, vld;
    int num_errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int mdl [256];
    int status = 0;
    int n, cnt;

    wdt_gpio_regs #(.CYCLES_PER_SEC(CPS)) wdt_gpio_regs_i (
        .i_clock(i_clock), .i_reset(i_reset), .i_io_addr(io_addr), .i_io_wdata(io_wdata),
        .i_io_write(io_write), .i_io_read(io_read), .o_io_rdata(io_rdata),
        .o_io_rvalid(io_rvalid), .o_pin_level(pin_level), .o_pin_drive_en(pin_en),
        .o_wdt_reset(wdt_reset));
    io_host_model io_host_model_i (
        .i_clock(i_clock), .i_io_rdata(io_rdata), .i_io_rvalid(io_rvalid),
        .o_io_addr(io_addr), .o_io_wdata(io_wdata), .o_io_write(io_write),
        .o_io_read(io_read));

    always #12.5 i_clock = ~i_clock;

    // Hang guard: the whole run needs well under this many cycles
    always @(posedge i_clock) begin
        cycles++;
        if (cycles == 20000) begin
            num_errors++;
            give_verdict();
        end
    end

    task automatic give_verdict();
        $display("checks %0d, mismatches %0d", total_checks, num_errors);
        if (num_errors == 0 && total_checks > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : give_verdict

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        total_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : check

    function automatic bit mapped(input int ofs);
        foreach (PIN_DIR_OFFSET[p]) if (ofs == PIN_DIR_OFFSET[p]) return 1'b1;
        return ofs == OFS_WDT_ENABLE || ofs == OFS_PIN_OUTPUT_LEVEL || ofs == OFS_WDT_TIMEOUT_VALUE;
    endfunction : mapped

    // Write through the host and mirror it in the reference model
    task automatic wr(input logic [7:0] ofs, input logic [7:0] data);
        io_host_model_i.io_write(IO_BASE | {8'h00, ofs}, data);
        if (ofs == OFS_WDT_UNIT_CONFIG) begin
            mdl[ofs] = data & 8'h80;
            if (data[0]) status = 0;
        end else if (mapped(ofs)) mdl[ofs] = data;
    endtask : wr

    // Read one offset and compare with the model, status folded into bit 0
    task automatic rchk(input logic [7:0] ofs);
        io_host_model_i.io_read(IO_BASE | {8'h00, ofs}, rd, vld);
        check({7'h00, vld}, 8'h01);
        check(rd, 8'(mdl[ofs] | ((ofs == OFS_WDT_UNIT_CONFIG) ? status : 0)));
    endtask : rchk

    task automatic check_pins();
        repeat (2) @(posedge i_clock);
        #1;
        foreach (PIN_DIR_OFFSET[p]) exp_en[p] = (mdl[PIN_DIR_OFFSET[p]] == 0);
        check(pin_en, exp_en);
        check(pin_level, 8'(mdl[OFS_PIN_OUTPUT_LEVEL]));
    endtask : check_pins

    // Count edges until the timeout reset appears and compare with the unit count
    task automatic expect_timeout(input int units);
        cnt = 0;
        while (wdt_reset !== 1'b1 && cnt < units + 20) begin
            @(posedge i_clock);
            #1;
            cnt++;
        end
        // Reload one cycle after the write, status and reset one and two cycles after the timeout
        check(8'(cnt), 8'(units + 3));
        status = 1;
        rchk(OFS_WDT_UNIT_CONFIG);
        wr(OFS_WDT_UNIT_CONFIG, 8'(mdl[OFS_WDT_UNIT_CONFIG] | 1));
        rchk(OFS_WDT_UNIT_CONFIG);
        check({7'h00, wdt_reset}, 8'h00);
    endtask : expect_timeout

    initial begin
        foreach (mdl[k]) mdl[k] = 0;
        foreach (PIN_DIR_OFFSET[p]) mdl[PIN_DIR_OFFSET[p]] = RESET_DIRECTION;
        void'($urandom(32'hdcf56bc7));
        repeat (5) @(posedge i_clock);
        i_reset <= 1'b0;
        // Reset values, every offset of the window, and traffic outside it
        for (int k = 0; k < 256; k++) rchk(8'(k));
        check(pin_en | pin_level, 8'h00);
        check({7'h00, wdt_reset}, 8'h00);
        io_host_model_i.io_write(16'h0b4b, 8'hff);
        io_host_model_i.io_read(16'h0b4b, rd, vld);
        check({7'h00, vld}, 8'h00);
        check_pins();
        $display("test reset and decode done");
        // Random directions, including codes other than the two defined ones
        repeat (8) begin
            foreach (PIN_DIR_OFFSET[p]) begin
                n = $urandom % 3;
                wr(PIN_DIR_OFFSET[p], (n == 2) ? 8'($urandom | 2) : 8'(n));
            end
            wr(OFS_PIN_OUTPUT_LEVEL, 8'($urandom));
            wr(8'h28, 8'($urandom));
            check_pins();
            foreach (PIN_DIR_OFFSET[p]) rchk(PIN_DIR_OFFSET[p]);
            rchk(8'h28);
        end
        foreach (PIN_DIR_OFFSET[p]) wr(PIN_DIR_OFFSET[p], (p == 0) ? 8'h00 : 8'h01);
        wr(OFS_PIN_OUTPUT_LEVEL, 8'h01);
        check_pins();
        $display("test pins done");
        // Seconds unit with a restart part way through the count
        n = 1 + $urandom % 3;
        wr(OFS_WDT_UNIT_CONFIG, 8'h80);
        wr(OFS_WDT_ENABLE, WDT_ENABLE_CODE);
        wr(OFS_WDT_TIMEOUT_VALUE, 8'(n));
        // Kick before the first unit ends, so a missed restart shows in the cycle count
        repeat (1) @(posedge i_clock);
        wr(OFS_WDT_TIMEOUT_VALUE, 8'(n));
        expect_timeout(n * CPS);
        $display("test seconds timeout done");
        // Zero value and a wrong enable code must never time out
        wr(OFS_WDT_TIMEOUT_VALUE, 8'h00);
        repeat (300) @(posedge i_clock);
        wr(OFS_WDT_ENABLE, 8'h0b);
        wr(OFS_WDT_TIMEOUT_VALUE, 8'h01);
        repeat (100) @(posedge i_clock);
        #1;
        check({7'h00, wdt_reset}, 8'h00);
        rchk(OFS_WDT_UNIT_CONFIG);
        $display("test disabled timer done");
        // Minutes unit, loaded by the enable write
        wr(OFS_WDT_UNIT_CONFIG, 8'h00);
        wr(OFS_WDT_ENABLE, WDT_ENABLE_CODE);
        expect_timeout(SECONDS_PER_MINUTE * CPS);
        rchk(OFS_WDT_TIMEOUT_VALUE);
        $display("test minutes timeout done");
        give_verdict();
    end
endmodule : test_watchdog_and_gpio_runtime_regs
`default_nettype wire
